// ### rtl/addr_mode_regs.vh
`ifndef ADDR_MODE_REGS_VH
`define ADDR_MODE_REGS_VH

// Addressing mode codes
`define AM_INHERENT      4'h0
`define AM_IMMEDIATE     4'h1
`define AM_DIRECT_SHORT  4'h2
`define AM_DIRECT_LONG   4'h3
`define AM_INDEXED_NONE  4'h4
`define AM_INDEXED_SHORT 4'h5
`define AM_INDEXED_LONG  4'h6
`define AM_INDIRECT_SHORT 4'h7
`define AM_INDIRECT_LONG 4'h8

// Address width and byte width
`define ADDR_W           16
`define DATA_W           8

// Reset values
`define RST_ADDR         16'h0000
`define RST_BYTE         8'h00

`endif

// ### rtl/mode_length.v
`timescale 1ns/1ps
`include "addr_mode_regs.vh"

module mode_length (
  input  wire [3:0] mode_i,      // Addressing mode code
  output reg  [1:0] ext_bytes_o, // Bytes that follow the opcode
  output reg        indirect_o,  // Mode fetches a pointer
  output reg        ptr_long_o,  // Pointer is a word
  output reg        indexed_o,   // Mode adds an index register
  output reg        imm_o        // Byte is an operand value
);

  always @* begin
    ext_bytes_o = 2'h0;
    indirect_o  = 1'b0;
    ptr_long_o  = 1'b0;
    indexed_o   = 1'b0;
    imm_o       = 1'b0;
    case (mode_i)
      `AM_INHERENT: begin
        ext_bytes_o = 2'h0; // [RULE1] [RULE2]
      end
      `AM_IMMEDIATE: begin
        ext_bytes_o = 2'h1; // [RULE3]
        imm_o       = 1'b1;
      end
      `AM_DIRECT_SHORT: begin
        ext_bytes_o = 2'h1; // [RULE4]
      end
      `AM_DIRECT_LONG: begin
        ext_bytes_o = 2'h2; // [RULE5]
      end
      `AM_INDEXED_NONE: begin
        ext_bytes_o = 2'h0; // [RULE7]
        indexed_o   = 1'b1;
      end
      `AM_INDEXED_SHORT: begin
        ext_bytes_o = 2'h1; // [RULE8]
        indexed_o   = 1'b1;
      end
      `AM_INDEXED_LONG: begin
        ext_bytes_o = 2'h2; // [RULE9]
        indexed_o   = 1'b1;
      end
      `AM_INDIRECT_SHORT: begin
        ext_bytes_o = 2'h1; // [RULE11]
        indirect_o  = 1'b1;
      end
      `AM_INDIRECT_LONG: begin
        ext_bytes_o = 2'h1; // [RULE12]
        indirect_o  = 1'b1;
        ptr_long_o  = 1'b1;
      end
      default: begin
        ext_bytes_o = 2'h0;
      end
    endcase
  end

endmodule

// ### rtl/addr_mode_decode.v
// Notes on behaviour
// RULE1: Inherent instructions are one byte; nothing is fetched after the opcode.
// RULE2: For inherent instructions the opcode alone defines the operation.
// RULE3: Immediate is two bytes; the second byte is the operand value itself.
// RULE4: Short direct: one address byte follows, operand lies in 00 to FF.
// RULE5: Long direct: two bytes follow forming a 16-bit operand address.
// RULE6: Indexed address is the unsigned sum of index register and offset.
// RULE7: Indexed without offset: no byte follows; index alone is the address.
// RULE8: Short indexed: one offset byte added to index, range 00 to 1FE.
// RULE9: Long indexed: two-byte offset added to index, full 64 Kbyte space.
// RULE10: Indirect: byte after opcode locates a pointer; operand is at pointer.
// RULE11: Short indirect reads a one-byte pointer; operand in 00 to FF.
// RULE12: Long indirect reads a 16-bit pointer; operand anywhere in 64 Kbyte.
// RULE13: Two-byte values take the high byte from the lower memory address.
`timescale 1ns/1ps
`include "addr_mode_regs.vh"

module addr_mode_decode (
  input  wire        clk_i,        // Core clock
  input  wire        rstn_i,       // Synchronous reset, active low
  input  wire        start_i,      // Pulse: opcode byte is at pc_i
  input  wire [3:0]  mode_i,       // Addressing mode of the opcode
  input  wire        use_y_i,      // Select second index register
  input  wire [15:0] pc_i,         // Address of the opcode
  input  wire [7:0]  index_x_i,    // First index register
  input  wire [7:0]  index_y_i,    // Second index register
  output reg         mem_req_o,    // Memory read request
  output reg  [15:0] mem_addr_o,   // Memory read address
  input  wire        mem_ack_i,    // Memory read data valid
  input  wire [7:0]  mem_data_i,   // Memory read data
  output reg         busy_o,       // Decode in progress
  output reg         done_o,       // Pulse: results valid
  output reg  [1:0]  length_o,     // Instruction length minus one
  output reg         has_addr_o,   // Operand is in memory
  output reg  [15:0] ea_o,         // Effective operand address
  output reg  [7:0]  imm_o,        // Immediate operand value
  output reg  [15:0] next_pc_o     // Address of next instruction
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [4:0] S_IDLE  = 5'b00001;
  localparam [4:0] S_EXT   = 5'b00010;
  localparam [4:0] S_PTR   = 5'b00100;
  localparam [4:0] S_DONE  = 5'b01000;
  localparam [4:0] S_SPARE = 5'b10000;

  wire [1:0] ext_bytes;
  wire       indirect;
  wire       ptr_long;
  wire       indexed;
  wire       immediate;

  reg  [4:0]  state_reg;
  reg  [3:0]  mode_reg;
  reg  [7:0]  index_reg;
  reg  [1:0]  need_reg;
  reg  [1:0]  got_reg;
  reg  [15:0] word_reg;
  reg  [15:0] fetch_addr_reg;

  wire [1:0] m_ext;
  wire       m_ind;
  wire       m_plong;
  wire       m_idx;
  wire       m_imm;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  // The latched mode steers decode once busy, so a start raised while
  // busy cannot change how the running fetch ends
  wire [3:0] mode_sel = (state_reg == S_IDLE) ? mode_i : mode_reg;

  mode_length u_len (
    .mode_i      (mode_sel),
    .ext_bytes_o (ext_bytes),
    .indirect_o  (indirect),
    .ptr_long_o  (ptr_long),
    .indexed_o   (indexed),
    .imm_o       (immediate)
  );

  assign m_ext   = ext_bytes;
  assign m_ind   = indirect;
  assign m_plong = ptr_long;
  assign m_idx   = indexed;
  assign m_imm   = immediate;

  // ****************************************************************
  // Byte assembly and address forming
  // ****************************************************************
  wire [15:0] word_next = {word_reg[7:0], mem_data_i}; // [RULE13]
  wire [7:0]  sel_index = use_y_i ? index_y_i : index_x_i;

  function [15:0] form_ea;
    input [3:0]  mode;
    input [15:0] word;
    input [7:0]  idx;
    begin
      case (mode)
        `AM_DIRECT_SHORT:  form_ea = {8'h00, word[7:0]};              // [RULE4]
        `AM_DIRECT_LONG:   form_ea = word;                            // [RULE5]
        `AM_INDEXED_NONE:  form_ea = {8'h00, idx};                    // [RULE7]
        `AM_INDEXED_SHORT: form_ea = {7'h00, {1'b0, idx} + {1'b0, word[7:0]}}; // [RULE6] [RULE8]
        `AM_INDEXED_LONG:  form_ea = word + {8'h00, idx};             // [RULE6] [RULE9]
        default:           form_ea = word;
      endcase
    end
  endfunction

  // ****************************************************************
  // Result forming
  // ****************************************************************
  // Inherent and immediate operands never name a memory location
  wire        has_addr_next = (mode_reg != `AM_INHERENT) && !m_imm;   // [RULE2] [RULE3]
  wire [7:0]  imm_next      = m_imm ? word_reg[7:0] : `RST_BYTE;      // [RULE3]
  wire [15:0] ea_next       = form_ea(mode_reg, word_reg, index_reg); // [RULE6] [RULE10]
  // Pointers live in page zero; the operand byte is their address
  wire [15:0] ptr_loc       = {8'h00, mem_data_i};                    // [RULE10]
  // Byte now acknowledged is the last one this phase needs
  wire        last_byte     = (got_reg + 2'h1 == need_reg);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg      <= S_IDLE;
      mode_reg       <= `AM_INHERENT;
      index_reg      <= `RST_BYTE;
      need_reg       <= 2'h0;
      got_reg        <= 2'h0;
      word_reg       <= `RST_ADDR;
      fetch_addr_reg <= `RST_ADDR;
      mem_req_o      <= 1'b0;
      mem_addr_o     <= `RST_ADDR;
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      length_o       <= 2'h0;
      has_addr_o     <= 1'b0;
      ea_o           <= `RST_ADDR;
      imm_o          <= `RST_BYTE;
      next_pc_o      <= `RST_ADDR;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_i) begin
            mode_reg  <= mode_i;
            index_reg <= m_idx ? sel_index : `RST_BYTE; // [RULE6]
            need_reg  <= m_ext;
            got_reg   <= 2'h0;
            word_reg  <= `RST_ADDR;
            length_o  <= m_ext;
            next_pc_o <= pc_i + {14'h0000, m_ext} + 16'h0001;
            busy_o    <= 1'b1;
            if (m_ext == 2'h0) begin
              // No operand bytes: finish next cycle
              state_reg <= S_DONE; // [RULE1] [RULE7]
            end else begin
              mem_req_o      <= 1'b1;
              mem_addr_o     <= pc_i + 16'h0001;
              fetch_addr_reg <= pc_i + 16'h0001;
              state_reg      <= S_EXT;
            end
          end
        end
        S_EXT: begin
          if (mem_ack_i) begin
            word_reg <= word_next;
            got_reg  <= got_reg + 2'h1;
            if (last_byte) begin
              if (m_ind) begin
                // Operand byte names the pointer location
                mem_addr_o     <= ptr_loc; // [RULE10]
                fetch_addr_reg <= ptr_loc;
                got_reg        <= 2'h0;
                need_reg       <= m_plong ? 2'h2 : 2'h1; // [RULE11] [RULE12]
                state_reg      <= S_PTR;
              end else begin
                mem_req_o <= 1'b0;
                state_reg <= S_DONE;
              end
            end else begin
              // More operand bytes: step to the next address
              mem_addr_o     <= fetch_addr_reg + 16'h0001;
              fetch_addr_reg <= fetch_addr_reg + 16'h0001;
            end
          end
        end
        S_PTR: begin
          if (mem_ack_i) begin
            word_reg <= word_next; // [RULE13]
            got_reg  <= got_reg + 2'h1;
            if (last_byte) begin
              mem_req_o <= 1'b0;
              // Short pointers zero-extend; long ones arrive high byte first
              word_reg  <= m_plong ? word_next : ptr_loc; // [RULE11] [RULE12]
              state_reg <= S_DONE;
            end else begin
              mem_addr_o     <= fetch_addr_reg + 16'h0001;
              fetch_addr_reg <= fetch_addr_reg + 16'h0001;
            end
          end
        end
        S_DONE: begin
          // has_addr_o, imm_o and ea_o stand until the next decode completes
          busy_o     <= 1'b0;
          done_o     <= 1'b1;
          has_addr_o <= has_addr_next; // [RULE2] [RULE3]
          imm_o      <= imm_next;      // [RULE3]
          ea_o       <= ea_next;       // [RULE10]
          state_reg  <= S_IDLE;
        end
        default: begin
          mem_req_o <= 1'b0;
          busy_o    <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ### testbench/addr_mode_checker.sv
`timescale 1ns/1ps
module addr_mode_checker (
  input wire        clk_i,      // Core clock
  input wire        rstn_i,     // Reset, active low
  input wire        start_i,    // Decode request
  input wire [3:0]  mode_i,     // Addressing mode
  input wire [15:0] pc_i,       // Opcode address
  input wire        mem_req_o,  // Read request
  input wire [15:0] mem_addr_o, // Read address
  input wire        busy_o,     // Decode in progress
  input wire        done_o,     // Results valid
  input wire [1:0]  length_o,   // Bytes after opcode
  input wire        has_addr_o, // Operand in memory
  input wire [15:0] ea_o        // Effective address
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire go = start_i && !busy_o;
  property p_inh; go && mode_i == 4'h0 |=> !mem_req_o [*2]; endproperty
  a_inh: assert property (p_inh)
    else $error("inherent mode fetched a byte");
  property p_imm; go && mode_i == 4'h1 |=> length_o == 2'h1; endproperty
  a_imm: assert property (p_imm)
    else $error("immediate length wrong");
  property p_dl; go && mode_i == 4'h3 |=> mem_req_o && mem_addr_o == $past(pc_i) + 16'h1;
  endproperty
  a_dl: assert property (p_dl)
    else $error("long direct first fetch address wrong");
  property p_has; done_o |-> has_addr_o == (mode_i > 4'h1); endproperty
  a_has: assert property (p_has)
    else $error("operand address flag wrong");
  property p_ds; done_o && mode_i == 4'h2 |-> ea_o[15:8] == 8'h00; endproperty
  a_ds: assert property (p_ds)
    else $error("short direct beyond first page");
  property p_in; done_o && mode_i == 4'h4 |-> ea_o[15:8] == 8'h00 && length_o == 2'h0;
  endproperty
  a_in: assert property (p_in)
    else $error("indexed without offset wrong");
  property p_is; done_o && mode_i == 4'h5 |-> ea_o <= 16'h01FE; endproperty
  a_is: assert property (p_is)
    else $error("short indexed beyond 1FE");
  property p_ist; done_o && mode_i == 4'h7 |-> ea_o[15:8] == 8'h00; endproperty
  a_ist: assert property (p_ist)
    else $error("short indirect beyond first page");
  property p_end; go |-> ##[2:60] done_o; endproperty
  a_end: assert property (p_end)
    else $error("decode never completed");
endmodule

// ### testbench/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input  wire        clk_i,  // Core clock
  input  wire        req_i,  // Read request
  input  wire [15:0] addr_i, // Read address
  input  wire [1:0]  lat_i,  // Wait cycles before answer
  output wire        ack_o,  // Byte valid
  output wire [7:0]  data_o  // Read byte
);
  reg  [1:0] wait_reg = 2'h0;
  wire [7:0] byte_w = addr_i[7:0] ^ addr_i[15:8] ^ 8'h3C;
  assign ack_o = req_i && (wait_reg == lat_i);
  // Inverse byte outside the answer exposes stale reads
  assign data_o = ack_o ? byte_w : ~byte_w;
  always @(posedge clk_i) begin
    wait_reg <= (req_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
  end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg        clk_i = 0, rstn_i = 0, start_i = 0, use_y_i = 0;
  reg [3:0]  mode_i = 0;
  reg [15:0] pc_i = 0;
  reg [7:0]  index_x_i = 0, index_y_i = 0;
  reg [1:0]  lat = 0;
  wire       mem_req_o, mem_ack_i, busy_o, done_o, has_addr_o;
  wire [15:0] mem_addr_o, ea_o, next_pc_o;
  wire [7:0] mem_data_i, imm_o;
  wire [1:0] length_o;
  integer    miscompares = 0, total_checks = 0;
  addr_mode_decode addr_mode_decode_i (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .start_i    (start_i),
    .mode_i     (mode_i),
    .use_y_i    (use_y_i),
    .pc_i       (pc_i),
    .index_x_i  (index_x_i),
    .index_y_i  (index_y_i),
    .mem_req_o  (mem_req_o),
    .mem_addr_o (mem_addr_o),
    .mem_ack_i  (mem_ack_i),
    .mem_data_i (mem_data_i),
    .busy_o     (busy_o),
    .done_o     (done_o),
    .length_o   (length_o),
    .has_addr_o (has_addr_o),
    .ea_o       (ea_o),
    .imm_o      (imm_o),
    .next_pc_o  (next_pc_o)
  );
  mem_model mem_model_i (.clk_i(clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
    .lat_i(lat), .ack_o(mem_ack_i), .data_o(mem_data_i));
  initial forever #50 clk_i = ~clk_i;
  function [7:0] mb(input [15:0] a);
    mb = a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  task chk(input ok, input [8*8:1] what);
    begin
      total_checks = total_checks + 1;
      if (ok !== 1'b1) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t %0s", $time, what);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task run(input [3:0] m, input [15:0] pc, input [7:0] ix, input [1:0] l, input again);
    reg [7:0] b1;
    reg [15:0] w, ea;
    reg [1:0] len;
    integer n;
    begin
      b1 = mb(pc + 16'h1);
      w = {b1, mb(pc + 16'h2)};
      len = (m == 0 || m == 4) ? 2'h0 : (m == 3 || m == 6) ? 2'h2 : 2'h1;
      case (m)
        2, 7: ea = {8'h00, b1};
        3: ea = w;
        4: ea = {8'h00, ix};
        5: ea = ix + b1;
        6: ea = w + ix;
        8: ea = {mb({8'h00, b1}), mb({8'h00, b1} + 16'h1)};
        default: ea = 16'h0000;
      endcase
      if (m == 7) ea = {8'h00, mb(ea)};
      @(posedge clk_i);
      mode_i <= m; pc_i <= pc; lat <= l; start_i <= 1'b1; use_y_i <= m[0];
      index_x_i <= m[0] ? ~ix : ix; index_y_i <= m[0] ? ix : ~ix;
      @(posedge clk_i);
      start_i <= again; pc_i <= ~pc;
      #1 chk(busy_o === 1'b1, "busy");
      if (again) @(posedge clk_i) start_i <= 1'b0;
      #1;
      for (n = 0; n < 60 && done_o !== 1'b1; n = n + 1) @(posedge clk_i) #1;
      if (n == 60) begin
        chk(1'b0, "timeout");
        finish_test;
      end else begin
        chk(busy_o === 1'b0 && mem_req_o === 1'b0, "idle");
        chk(length_o === len, "length");
        chk(next_pc_o === pc + 16'h1 + len, "next pc");
        chk(has_addr_o === (m > 1), "has addr");
        if (m == 1) chk(imm_o === b1, "imm");
        if (m > 1) chk(ea_o === ea, "ea");
      end
    end
  endtask
  task t_prompt;
    integer m;
    begin
      for (m = 0; m < 9; m = m + 1) run(m, 16'h0340 + m * 5, 8'hA7, 2'h0, 1'b0);
      $display("prompt memory test done");
    end
  endtask
  task t_slow;
    integer m;
    begin
      for (m = 0; m < 9; m = m + 1) run(m, 16'h8F10 + m * 3, 8'h5E, 2'h3, 1'b0);
      $display("slow memory test done");
    end
  endtask
  task t_edge;
    begin
      run(4'h5, 16'h00C2, 8'hFF, 2'h1, 1'b0);
      run(4'h6, 16'hFFF0, 8'hFF, 2'h2, 1'b0);
      $display("boundary test done");
    end
  endtask
  task t_refuse;
    begin
      run(4'h0, 16'h1000, 8'h11, 2'h0, 1'b1);
      run(4'h3, 16'h2000, 8'h22, 2'h2, 1'b1);
      $display("busy refusal test done");
    end
  endtask
  task t_reset;
    begin
      @(posedge clk_i);
      mode_i <= 4'h8; pc_i <= 16'h4A00; lat <= 2'h3; start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      #1 chk(busy_o === 1'b0 && mem_req_o === 1'b0 && done_o === 1'b0, "reset");
      chk(next_pc_o === 16'h0000 && length_o === 2'h0 && ea_o === 16'h0000, "reset");
      @(posedge clk_i) #1;
      chk(has_addr_o === 1'b0 && imm_o === 8'h00 && mem_addr_o === 16'h0000, "release");
      run(4'h8, 16'h4A00, 8'h3D, 2'h3, 1'b0);
      $display("mid-run reset test done");
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_prompt;
    t_slow;
    t_edge;
    t_refuse;
    t_reset;
    finish_test;
  end
endmodule
bind addr_mode_decode addr_mode_checker addr_mode_checker_i (
  .clk_i      (clk_i),
  .rstn_i     (rstn_i),
  .start_i    (start_i),
  .mode_i     (mode_i),
  .pc_i       (pc_i),
  .mem_req_o  (mem_req_o),
  .mem_addr_o (mem_addr_o),
  .busy_o     (busy_o),
  .done_o     (done_o),
  .length_o   (length_o),
  .has_addr_o (has_addr_o),
  .ea_o       (ea_o)
);
